/* File: core/tpc_pkg.sv */
package tpc_pkg;
  localparam logic [11:0] SC_OFS = 12'h000;
  localparam logic [11:0] CNTH_OFS = 12'h004;
  localparam logic [11:0] CNTL_OFS = 12'h008;
  localparam logic [11:0] MOD_OFS = 12'h00C;
  localparam logic [11:0] IST_OFS = 12'h010;
  localparam logic [11:0] IMSK_OFS = 12'h014;
  localparam int CH_FIRST = 2;
  localparam logic [3:0] CH_CSC = 4'h0;
  localparam logic [3:0] CH_VH = 4'h4;
  localparam logic [3:0] CH_VL = 4'h8;
  localparam int SC_OVF = 7;
  localparam int SC_OIE = 6;
  localparam int SC_CPWM = 5;
  localparam int SC_CLK = 3;
  localparam int SC_PS = 0;
  localparam int CSC_MODE = 2;
  localparam int CSC_ELS = 0;
  localparam int PS_W = 3;
  localparam int PCNT_W = 7;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_FULL = 16'hFFFF;
  localparam logic [PCNT_W:0] PS_ONE = 8'h01;
  localparam logic [PCNT_W-1:0] PCNT_ONE = 7'h01;

  typedef enum logic [1:0] {
    CLK_OFF = 2'b00,
    CLK_BUS = 2'b01,
    CLK_EXT = 2'b10,
    CLK_EXT2 = 2'b11
  } tpc_clk_e;

  typedef enum logic [1:0] {
    MODE_CAP = 2'b00,
    MODE_CMP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_PWM2 = 2'b11
  } tpc_mode_e;

  typedef enum logic {
    DIR_DOWN = 1'b0,
    DIR_UP = 1'b1
  } tpc_dir_e;

  localparam logic [1:0] ELS_PORT = 2'b00;
  localparam logic [1:0] ELS_TOGGLE = 2'b01;
  localparam logic [1:0] ELS_CLEAR = 2'b10;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] els;
  } tpc_chcfg_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic stepped;
    logic topStep;
    logic tick;
    logic center;
    logic up;
    logic clkOn;
  } tpc_ctr_s;
endpackage

/* File: core/tpc_chan.sv */
`timescale 1ns/100ps
`default_nettype none
module tpc_chan
  import tpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire tpc_ctr_s ctr,
  input wire tpc_chcfg_s cfg,
  input wire logic scWr,
  input wire logic valHiWr,
  input wire logic valLoWr,
  input wire logic [7:0] wByte,
  input wire logic pinIn,
  output logic [15:0] val_r,
  output logic pinOut_r,
  output logic pinOe_r,
  output logic evt_r
);
  logic hiDone_r, loDone_r, pend_r, pinPrev_r;
  logic [15:0] buf_r;
  logic pwm, cap, hiW, loW, done, match, loadNow, capEvt, hiTrue;

  assign pwm = ctr.center || cfg.mode[1];
  assign cap = !ctr.center && (cfg.mode == MODE_CAP);
  assign hiW = valHiWr && !cap;
  assign loW = valLoWr && !cap;
  assign done = (hiW && loDone_r) || (loW && hiDone_r);
  assign match = ctr.stepped && (ctr.cnt == val_r);
  assign capEvt = cap && ((cfg.els[0] && pinIn && !pinPrev_r) || (cfg.els[1] && !pinIn && pinPrev_r));
  assign hiTrue = !cfg.els[0];
  assign loadNow = pwm ? ctr.topStep : (!ctr.clkOn || ctr.tick);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hiDone_r <= 1'b0;
      loDone_r <= 1'b0;
    end else if (ce) begin
      if (scWr || done) begin
        hiDone_r <= 1'b0;
        loDone_r <= 1'b0;
      end else begin
        if (hiW) hiDone_r <= 1'b1;
        if (loW) loDone_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      buf_r <= CNT_ZERO;
      pend_r <= 1'b0;
      val_r <= CNT_ZERO;
    end else if (ce) begin
      if (hiW) buf_r[15:8] <= wByte;
      if (loW) buf_r[7:0] <= wByte;
      pend_r <= done || (pend_r && !loadNow);
      if (capEvt) val_r <= ctr.cnt;
      else if (pend_r && loadNow) val_r <= buf_r;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinOut_r <= 1'b0;
      pinOe_r <= 1'b0;
      pinPrev_r <= 1'b0;
      evt_r <= 1'b0;
    end else if (ce) begin
      pinPrev_r <= pinIn;
      pinOe_r <= !cap && (cfg.els != ELS_PORT);
      evt_r <= cap ? capEvt : match;
      if (!cap) begin
        if (pwm && ctr.center) begin
          if (match) pinOut_r <= ctr.up ? !hiTrue : hiTrue;
        end else if (pwm) begin
          if (match) pinOut_r <= !hiTrue;
          else if (ctr.stepped && ctr.cnt == CNT_ZERO) pinOut_r <= hiTrue;
        end else if (match) begin
          case (cfg.els)
            ELS_CLEAR: pinOut_r <= 1'b0;
            ELS_TOGGLE, ELS_PORT: pinOut_r <= !pinOut_r;
            default: pinOut_r <= 1'b1;
          endcase
        end
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_pwm_load_top: assert property (ce && pwm && pend_r && ctr.topStep && !capEvt |=> val_r == $past(buf_r))
    else $error("pwm value not loaded at top step");
  a_pwm_hold: assert property (ce && pwm && !ctr.topStep && !capEvt |=> val_r == $past(val_r))
    else $error("pwm value changed off the top step");
  a_pair_reset: assert property (ce && scWr |=> !hiDone_r && !loDone_r)
    else $error("byte pairing not reset by control write");
  a_port_ctrl: assert property (ce && cfg.els == ELS_PORT |=> !pinOe_r)
    else $error("pin driven while left to port");
endmodule
`default_nettype wire

/* File: core/tpc_core.sv */
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module tpc_core
  import tpc_pkg::*;
#(
  parameter int NCH = 2
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic extTick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] chPinIn,
  output logic [NCH-1:0] chPinOut,
  output logic [NCH-1:0] chPinOe,
  output logic irq
);
  logic [PS_W-1:0] ps_r;
  tpc_clk_e clkSel_r;
  logic center_r;
  logic [15:0] mod_r, cnt_r, cntLat_r, term;
  logic [PCNT_W-1:0] pcnt_r, psMask;
  tpc_dir_e dir_r;
  logic latV_r, latHi_r, stepped_r;
  logic [NCH:0] ist_r, imsk_r, evtAll;
  logic pready_r, pslverr_r, irq_r;
  logic [31:0] prdata_r, rdData;
  logic hit, setup, acc, wr, scWr, cntWr, istWr, imskWr, modWr;
  logic rdCntH, rdCntL;
  logic srcEdge, tick, ovfEvt, topStep;
  logic [NCH-1:0] chEvt;
  logic [15:0] chVal [NCH];
  tpc_chcfg_s chCfg_r [NCH];
  tpc_ctr_s ctr;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

  // bus decode: setup edge answers, access edge writes
  assign setup = psel && !pready_r;
  assign acc = psel && penable && pready_r;
  assign wr = acc && pwrite;
  assign scWr = wr && (paddr == SC_OFS);
  assign cntWr = wr && (paddr == CNTH_OFS || paddr == CNTL_OFS);
  assign istWr = wr && (paddr == IST_OFS);
  assign imskWr = wr && (paddr == IMSK_OFS);
  assign modWr = wr && (paddr == MOD_OFS);
  assign rdCntH = setup && !pwrite && (paddr == CNTH_OFS);
  assign rdCntL = setup && !pwrite && (paddr == CNTL_OFS);

  always_comb begin
    rdData = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      SC_OFS: rdData[7:0] = {ist_r[0], imsk_r[0], center_r, clkSel_r, ps_r};
      CNTH_OFS: rdData[7:0] = (latV_r && !latHi_r) ? cntLat_r[15:8] : cnt_r[15:8];
      CNTL_OFS: rdData[7:0] = (latV_r && latHi_r) ? cntLat_r[7:0] : cnt_r[7:0];
      MOD_OFS: rdData[15:0] = mod_r;
      IST_OFS: rdData[NCH:0] = ist_r;
      IMSK_OFS: rdData[NCH:0] = imsk_r;
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (paddr[11:4] == 8'(CH_FIRST + i)) begin
        hit = 1'b1;
        case (paddr[3:0])
          CH_CSC: rdData[3:0] = {chCfg_r[i].mode, chCfg_r[i].els};
          CH_VH: rdData[7:0] = chVal[i][15:8];
          CH_VL: rdData[7:0] = chVal[i][7:0];
          default: hit = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      pready_r <= setup;
      pslverr_r <= setup && !hit;
      if (setup) prdata_r <= (hit && !pwrite) ? rdData : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ps_r <= '0;
      clkSel_r <= CLK_OFF;
      center_r <= 1'b0;
    end else if (ce && scWr) begin
      ps_r <= pwdata[SC_PS +: PS_W];
      clkSel_r <= tpc_clk_e'(pwdata[SC_CLK +: 2]);
      center_r <= pwdata[SC_CPWM];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mod_r <= CNT_ZERO;
    end else if (ce && modWr) begin
      mod_r <= pwdata[15:0];
    end
  end

  // prescaler: divide by 2 to the power ps
  assign psMask = PCNT_W'((PS_ONE << ps_r) - PS_ONE);
  assign srcEdge = (clkSel_r == CLK_BUS) || ((clkSel_r != CLK_OFF) && extTick);
  assign tick = ce && srcEdge && (pcnt_r == psMask) && !cntWr;
  // terminal count is full or modulus
  assign term = (mod_r == CNT_ZERO) ? CNT_FULL : mod_r;
  assign ovfEvt = tick && (dir_r == DIR_UP) && (cnt_r == term);
  assign topStep = tick && (dir_r == DIR_UP) && (cnt_r == term - CNT_ONE);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pcnt_r <= '0;
    end else if (ce) begin
      if (cntWr || tick) pcnt_r <= '0;
      else if (srcEdge) pcnt_r <= pcnt_r + PCNT_ONE;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= CNT_ZERO;
      dir_r <= DIR_UP;
    end else if (ce) begin
      if (cntWr) begin
        cnt_r <= CNT_ZERO;
        dir_r <= DIR_UP;
      end else if (tick) begin
        case (dir_r)
          DIR_UP: begin
            if (cnt_r != term) begin
              cnt_r <= cnt_r + CNT_ONE;
            end else if (center_r && term != CNT_ZERO) begin
              cnt_r <= cnt_r - CNT_ONE;
              dir_r <= DIR_DOWN;
            end else begin
              cnt_r <= CNT_ZERO;
            end
          end
          DIR_DOWN: begin
            if (cnt_r == CNT_ZERO || !center_r) begin
              cnt_r <= cnt_r + CNT_ONE;
              dir_r <= DIR_UP;
            end else begin
              cnt_r <= cnt_r - CNT_ONE;
            end
          end
          default: dir_r <= DIR_UP;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stepped_r <= 1'b0;
    end else if (ce) begin
      stepped_r <= tick;
    end
  end

  // first half read latches the whole count
  // counter write drops the latch
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      latV_r <= 1'b0;
      latHi_r <= 1'b0;
      cntLat_r <= CNT_ZERO;
    end else if (ce) begin
      if (cntWr) begin
        latV_r <= 1'b0;
      end else if (rdCntH || rdCntL) begin
        if (latV_r && (latHi_r != rdCntH)) begin
          latV_r <= 1'b0;
        end else begin
          latV_r <= 1'b1;
          latHi_r <= rdCntH;
          cntLat_r <= cnt_r;
        end
      end
    end
  end

  assign evtAll = {chEvt, ovfEvt};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ist_r <= '0;
    end else if (ce) begin
      ist_r <= (ist_r & ~(istWr ? pwdata[NCH:0] : '0)) | evtAll;
    end
  end

  // mask bit 0 is the overflow enable, also seen in status and control
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      imsk_r <= '0;
    end else if (ce) begin
      if (imskWr) imsk_r <= pwdata[NCH:0];
      else if (scWr) imsk_r[0] <= pwdata[SC_OIE];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= |(ist_r & imsk_r);
    end
  end

  assign ctr = '{cnt: cnt_r, stepped: stepped_r, topStep: topStep, tick: tick,
                 center: center_r, up: dir_r == DIR_UP, clkOn: clkSel_r != CLK_OFF};

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [11:0] base;
    assign base = {8'(CH_FIRST + i), 4'h0};

    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        chCfg_r[i] <= '0;
      end else if (ce && wr && paddr == (base | 12'(CH_CSC))) begin
        chCfg_r[i] <= '{mode: pwdata[CSC_MODE +: 2], els: pwdata[CSC_ELS +: 2]};
      end
    end

    tpc_chan u_chan (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .ctr(ctr),
      .cfg(chCfg_r[i]),
      .scWr(scWr),
      .valHiWr(wr && paddr == (base | 12'(CH_VH))),
      .valLoWr(wr && paddr == (base | 12'(CH_VL))),
      .wByte(pwdata[7:0]),
      .pinIn(chPinIn[i]),
      .val_r(chVal[i]),
      .pinOut_r(chPinOut[i]),
      .pinOe_r(chPinOe[i]),
      .evt_r(chEvt[i])
    );
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_wrap_zero: assert property (tick && !center_r && cnt_r == term |=> cnt_r == CNT_ZERO)
    else $error("up counter did not wrap to zero");
  a_ovf_wrap: assert property (tick && !center_r && cnt_r == term |=> ist_r[0])
    else $error("overflow not set on wrap");
  a_ovf_only_top: assert property (ce && !ist_r[0] && !(tick && cnt_r == term) |=> !ist_r[0])
    else $error("overflow set away from terminal count");
  a_center_turn: assert property (tick && center_r && dir_r == DIR_UP && cnt_r == term && term != CNT_ZERO
    |=> cnt_r == $past(cnt_r) - CNT_ONE && dir_r == DIR_DOWN && ist_r[0])
    else $error("center counter did not turn at terminal count");
  a_center_bottom: assert property (tick && center_r && dir_r == DIR_DOWN && cnt_r == CNT_ZERO
    |=> cnt_r == CNT_ONE && dir_r == DIR_UP)
    else $error("center counter did not turn at zero");
  a_up_step: assert property (tick && !center_r && cnt_r != term && dir_r == DIR_UP
    |=> cnt_r == $past(cnt_r) + CNT_ONE)
    else $error("up counter did not advance by one");
  a_one_tick_state: assert property (ce && !tick && !cntWr |=> $stable(cnt_r))
    else $error("counter moved without a timer tick");
  a_cnt_clear: assert property (ce && cntWr |=> cnt_r == CNT_ZERO && pcnt_r == '0 && !latV_r)
    else $error("counter write did not clear counter, prescaler and latch");
  a_irq_level: assert property (ce |=> irq_r == $past(|(ist_r & imsk_r)))
    else $error("interrupt level does not follow masked flags");
  a_stopped: assert property (clkSel_r == CLK_OFF |-> !tick)
    else $error("counter ticks with no clock source");

  c_center_turn: cover property (tick && center_r && dir_r == DIR_UP && cnt_r == term);
  c_ovf_irq: cover property (ist_r[0] && imsk_r[0] ##1 irq_r);
  c_chan_evt: cover property (|chEvt);
  c_cnt_write: cover property (cntWr && latV_r);
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import tpc_pkg::*;
;
  localparam logic [11:0] CSC0 = 12'h020;
  localparam logic [11:0] VH0 = 12'h024;
  localparam logic [11:0] VL0 = 12'h028;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic extTick = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [1:0] chPinOut;
  logic [1:0] chPinOe;
  logic [31:0] rdData;
  logic rdErr;
  int nFail = 0;
  int totalChecks = 0;

  always #2.5 core_clk = ~core_clk;

  tpc_core #(.NCH(2)) i_tpc_core (
    .core_clk(core_clk), .nrst(nrst), .ce(1'b1), .extTick(extTick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chPinIn(2'b00), .chPinOut(chPinOut), .chPinOe(chPinOe), .irq(irq)
  );

  task automatic complete_run();
    if (nFail == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one transfer; the answer is taken at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    chk(n < 40, 1'b1, "no bus answer");
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      extTick <= 1'b1;
      @(posedge core_clk);
      extTick <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask

  task automatic rd_cnt(output logic [31:0] v);
    apb(1'b0, CNTH_OFS, 32'h0);
    v[15:8] = rdData[7:0];
    apb(1'b0, CNTL_OFS, 32'h0);
    v = {16'h0000, v[15:8], rdData[7:0]};
  endtask

  task automatic restart(input logic [31:0] sc, input logic [31:0] md);
    apb(1'b1, SC_OFS, 32'h0);
    apb(1'b1, MOD_OFS, md);
    apb(1'b1, CNTL_OFS, 32'h0);
    apb(1'b1, IST_OFS, 32'h1);
    apb(1'b1, SC_OFS, sc);
  endtask

  task automatic step_check(input logic [15:0] ex, input logic fl);
    logic [31:0] v;
    tick(1);
    rd_cnt(v);
    chk(v, {16'h0000, ex}, "count");
    apb(1'b0, IST_OFS, 32'h0);
    chk(rdData[0], fl, "overflow flag");
  endtask

  task automatic test_reset();
    logic [31:0] v;
    apb(1'b0, SC_OFS, 32'h0);
    chk(rdData, 32'h0, "status after reset");
    rd_cnt(v);
    chk(v, 32'h0, "count after reset");
    tick(2);
    rd_cnt(v);
    chk(v, 32'h0, "counter stopped");
    chk({irq, chPinOe}, 3'b000, "outputs after reset");
  endtask

  task automatic test_modulus();
    logic [15:0] ex [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0000, 16'h0001};
    logic fl [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    restart(32'h10, 32'h3);
    for (int i = 0; i < 5; i++) begin
      step_check(ex[i], fl[i]);
    end
  endtask

  task automatic test_center();
    logic [15:0] ex [5] = '{16'h0001, 16'h0002, 16'h0001, 16'h0000, 16'h0001};
    logic fl [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    restart(32'h30, 32'h2);
    for (int i = 0; i < 5; i++) begin
      step_check(ex[i], fl[i]);
    end
  endtask

  task automatic test_interrupt();
    apb(1'b0, SC_OFS, 32'h0);
    chk(rdData[7], 1'b1, "flag in status");
    chk(irq, 1'b0, "masked irq");
    apb(1'b1, IMSK_OFS, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b1, "unmasked irq");
    apb(1'b1, IMSK_OFS, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0, "irq after mask");
    apb(1'b1, IMSK_OFS, 32'h1);
    apb(1'b1, IST_OFS, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0, "irq after clear");
    apb(1'b0, IST_OFS, 32'h0);
    chk(rdData[0], 1'b0, "flag after clear");
    apb(1'b1, IMSK_OFS, 32'h0);
  endtask

  task automatic test_count_clear();
    logic [31:0] v;
    restart(32'h12, 32'h0);
    tick(3);
    rd_cnt(v);
    chk(v, 32'h0, "prescaled count");
    apb(1'b1, CNTH_OFS, 32'hA5);
    tick(3);
    rd_cnt(v);
    chk(v, 32'h0, "prescaler cleared");
    tick(1);
    rd_cnt(v);
    chk(v, 32'h1, "count after prescale");
    apb(1'b0, CNTH_OFS, 32'h0);
    tick(4);
    apb(1'b1, CNTL_OFS, 32'h5A);
    apb(1'b0, CNTL_OFS, 32'h0);
    chk(rdData, 32'h0, "stale latch dropped");
    apb(1'b0, CNTH_OFS, 32'h0);
    chk(rdData, 32'h0, "high byte after clear");
  endtask

  task automatic test_pwm_load();
    restart(32'h10, 32'h4);
    apb(1'b1, CSC0, 32'hA);
    @(posedge core_clk);
    chk(chPinOe[0], 1'b1, "pwm pin driven");
    apb(1'b1, VH0, 32'h0);
    apb(1'b1, VL0, 32'h2);
    tick(3);
    apb(1'b0, VL0, 32'h0);
    chk(rdData, 32'h0, "value held before top");
    tick(1);
    apb(1'b0, VL0, 32'h0);
    chk(rdData, 32'h2, "value loaded at top");
    apb(1'b1, CSC0, 32'h8);
    @(posedge core_clk);
    chk(chPinOe[0], 1'b0, "pin left to port");
    // pwm kept internal, wait overflow, then hand pin over
    apb(1'b1, IST_OFS, 32'h1);
    tick(1);
    apb(1'b0, IST_OFS, 32'h0);
    chk(rdData[0], 1'b1, "overflow before pin enable");
    apb(1'b1, CSC0, 32'hA);
    @(posedge core_clk);
    chk({chPinOe[0], chPinOut[0]}, 2'b11, "high-true pwm start");
    tick(2);
    chk(chPinOut[0], 1'b0, "pwm clears at match");
  endtask

  task automatic test_compare();
    apb(1'b1, CSC0, 32'h6);
    @(posedge core_clk);
    chk(chPinOe[0], 1'b1, "compare pin driven");
    apb(1'b1, VH0, 32'h12);
    apb(1'b1, SC_OFS, 32'h10);
    apb(1'b1, VL0, 32'h34);
    apb(1'b1, VH0, 32'h00);
    apb(1'b0, VL0, 32'h0);
    chk(rdData, 32'h2, "buffered until step");
    tick(1);
    apb(1'b0, VL0, 32'h0);
    chk(rdData, 32'h34, "low byte loaded");
    apb(1'b0, VH0, 32'h0);
    chk(rdData, 32'h0, "half pair dropped");
    apb(1'b1, CSC0, 32'h0);
    @(posedge core_clk);
    chk(chPinOe[0], 1'b0, "capture pin released");
    apb(1'b1, SC_OFS, 32'h0);
    apb(1'b1, VL0, 32'h55);
    apb(1'b1, VH0, 32'h55);
    repeat (2) @(posedge core_clk);
    apb(1'b0, VL0, 32'h0);
    chk(rdData, 32'h34, "capture write ignored");
  endtask

  task automatic test_unmapped();
    apb(1'b0, 12'h0FC, 32'h0);
    chk({rdErr, rdData}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    chk(rdErr, 1'b1, "unmapped write");
  endtask

  task automatic test_freerun();
    int n;
    restart(32'h08, 32'h0);
    repeat (65000) @(posedge core_clk);
    apb(1'b0, IST_OFS, 32'h0);
    chk(rdData[0], 1'b0, "no flag before wrap");
    n = 0;
    do begin
      apb(1'b0, IST_OFS, 32'h0);
      n++;
    end while (rdData[0] !== 1'b1 && n < 400);
    chk(rdData[0], 1'b1, "flag at wrap");
    apb(1'b1, SC_OFS, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    test_reset();
    test_unmapped();
    test_modulus();
    test_center();
    test_interrupt();
    test_count_clear();
    test_pwm_load();
    test_compare();
    test_freerun();
    complete_run();
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    nFail++;
    complete_run();
  end
endmodule
`default_nettype wire
